// ===== verilog/subskip_regs.vh
// Constants for the subtract, skip, swap and table-read execution block
`ifndef SUBSKIP_REGS_VH
`define SUBSKIP_REGS_VH

// Operation codes presented on op_code_in
`define OP_NONE        5'h00
`define OP_SBC_ACC     5'h01
`define OP_SBC_MEM     5'h02
`define OP_SUB_ACC     5'h03
`define OP_SUB_MEM     5'h04
`define OP_SUB_IMM     5'h05
`define OP_DEC_SKIP    5'h06
`define OP_DEC_SKIP_A  5'h07
`define OP_INC_SKIP    5'h08
`define OP_INC_SKIP_A  5'h09
`define OP_SET_BYTE    5'h0A
`define OP_SET_BIT     5'h0B
`define OP_BIT_SKIP_NZ 5'h0C
`define OP_BIT_SKIP_Z  5'h0D
`define OP_BYTE_SKIP_Z 5'h0E
`define OP_MOVE_SKIP_Z 5'h0F
`define OP_SWAP        5'h10
`define OP_SWAP_A      5'h11
`define OP_TAB_CUR     5'h12
`define OP_TAB_LAST    5'h13

// Field positions of the four-bit status word
`define FLAG_C_BIT     2'h0
`define FLAG_AUX_BIT   2'h1
`define FLAG_Z_BIT     2'h2
`define FLAG_OVF_BIT   2'h3

// Reset values and the all-ones pattern written by set byte
`define ACC_RESET      8'h00
`define FLAGS_RESET    4'h0
`define TABLE_HIGH_RESET 8'h00
`define BYTE_ALL_ONES  8'hFF

// Program memory geometry: 12-bit word address, 256-word pages
`define PAGE_HI_LAST   4'hF

`endif

// ===== verilog/sub_alu.v
// Eight-bit subtractor with borrow in and the four status outputs
`timescale 1ns/10ps
`default_nettype none
module sub_alu
(
  // Operands
  input  wire [7:0] a_in,
  input  wire [7:0] b_in,
  input  wire       carry_in,
  // Result and flags
  output wire [7:0] diff_out,
  output wire       c_out,
  output wire       aux_out,
  output wire       z_out,
  output wire       ovf_out
);
  wire [8:0] full;
  wire [4:0] low;
  // A - B - !C done as A + ~B + C, carry out is the not-borrow
  assign full     = {1'b0, a_in} + {1'b0, ~b_in} + {8'h00, carry_in};
  assign low      = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]}
                  + {4'h0, carry_in};
  assign diff_out = full[7:0];
  assign c_out    = full[8];
  assign aux_out  = low[4];
  assign z_out    = (full[7:0] == 8'h00);
  assign ovf_out  = (a_in[7] ^ b_in[7]) & (a_in[7] ^ full[7]);
endmodule // sub_alu
`default_nettype wire

// ===== verilog/subskip_exec.v
// Execution unit for subtract, skip, set, swap and table-read operations
//
// Contract
// RULE_01 - Subtract with borrow to memory: acc minus mem minus not carry.
// RULE_02 - Subtracts clear carry on negative result, set it otherwise.
// RULE_03 - Subtracts update overflow, zero, aux carry and carry flags.
// RULE_04 - Plain subtract puts acc minus mem in acc, no carry in.
// RULE_05 - Subtract-to-memory stores acc minus mem into the byte.
// RULE_06 - Subtract immediate: acc minus instruction constant into acc.
// RULE_07 - Decrement byte, write back, skip when the new value is zero.
// RULE_08 - Byte minus one into acc, memory kept, skip on zero.
// RULE_09 - Increment byte, write back, skip when wrapped result is zero.
// RULE_10 - Byte plus one into acc, memory kept, skip on zero.
// RULE_11 - A skipping instruction takes two cycles with a dummy cycle.
// RULE_12 - Set byte writes all ones and leaves flags alone.
// RULE_13 - Set bit forces only the selected bit to one.
// RULE_14 - Bit test skips when the selected bit is one.
// RULE_15 - Bit test skips when the selected bit is zero.
// RULE_16 - Byte test skips on zero, changing nothing.
// RULE_17 - Move byte to acc and skip when it is zero.
// RULE_18 - Swap nibbles of the byte in place, no flags.
// RULE_19 - Swapped byte goes to acc, memory unchanged.
// RULE_20 - Current-page table read: low byte to memory, high to table reg.
// RULE_21 - Last-page table read uses the final program page.
// RULE_22 - Skipped instruction has no side effect at all.
`timescale 1ns/10ps
`default_nettype none
`include "subskip_regs.vh"
module subskip_exec
(
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // Instruction issue
  input  wire        op_valid_in,
  input  wire [4:0]  op_code_in,
  input  wire [2:0]  bit_sel_in,
  input  wire [7:0]  imm_in,
  input  wire [7:0]  mem_rdata_in,
  input  wire [11:0] pc_in,
  input  wire [7:0]  table_pointer_in,
  input  wire [15:0] prog_rdata_in,
  // Data memory write
  output reg         mem_we_out,
  output reg  [7:0]  mem_wdata_out,
  // Program memory read for tables
  output reg         prog_re_out,
  output reg  [11:0] prog_addr_out,
  // Sequencing
  output wire        busy_out,
  output reg         skip_out,
  // Architectural state
  output wire [7:0]  acc_out,
  output wire [3:0]  flags_out,
  output wire [7:0]  table_high_byte_out
);
  localparam ST_RUN   = 2'h0;
  localparam ST_DUMMY = 2'h1;
  localparam ST_TABLE = 2'h2;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [7:0] acc_reg;
  reg  [7:0] acc_next;
  reg  [3:0] flags_reg;
  reg  [3:0] flags_next;
  reg  [7:0] table_high_reg;
  reg  [7:0] table_high_next;
  reg        we_next;
  reg  [7:0] wdata_next;
  reg        skip_next;
  reg        pre_next;
  reg [11:0] paddr_next;

  reg  [7:0] sub_b;
  reg        sub_cin;
  wire [7:0] diff;
  wire       d_c;
  wire       d_aux;
  wire       d_z;
  wire       d_ovf;
  wire [7:0] dec_val;
  wire [7:0] inc_val;
  wire [7:0] swapped;
  wire [7:0] bit_mask;
  wire       sel_bit;
  wire       take;

  // Subtract path shared by all subtract variants
  sub_alu u_alu
  (
    .a_in     (acc_reg),
    .b_in     (sub_b),
    .carry_in (sub_cin),
    .diff_out (diff),
    .c_out    (d_c),
    .aux_out  (d_aux),
    .z_out    (d_z),
    .ovf_out  (d_ovf)
  );

  // Issue is only honoured in the run state; the unit drops it otherwise
  assign take     = op_valid_in && (state_reg == ST_RUN);
  assign busy_out = (state_reg != ST_RUN);
  assign dec_val  = mem_rdata_in - 8'h01;
  assign inc_val  = mem_rdata_in + 8'h01;
  assign swapped  = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
  assign bit_mask = 8'h01 << bit_sel_in;
  assign sel_bit  = mem_rdata_in[bit_sel_in];

  assign acc_out             = acc_reg;
  assign flags_out           = flags_reg;
  assign table_high_byte_out = table_high_reg;

  always @*
  begin
    sub_b   = mem_rdata_in;
    sub_cin = 1'b1;
    if (op_code_in == `OP_SUB_IMM)
    begin
      sub_b = imm_in; // [RULE_06]
    end
    if ((op_code_in == `OP_SBC_ACC) || (op_code_in == `OP_SBC_MEM))
    begin
      sub_cin = flags_reg[`FLAG_C_BIT]; // [RULE_01]
    end
  end

  always @*
  begin
    state_next = ST_RUN;
    acc_next   = acc_reg;
    flags_next = flags_reg;
    table_high_next = table_high_reg;
    we_next    = 1'b0;
    wdata_next = mem_wdata_out;
    skip_next  = 1'b0;
    pre_next   = 1'b0;
    paddr_next = prog_addr_out;
    case (state_reg)
      ST_DUMMY:
      begin
        // Discarded slot: nothing architectural moves [RULE_22]
        state_next = ST_RUN;
      end
      ST_TABLE:
      begin
        we_next    = 1'b1; // [RULE_20]
        wdata_next = prog_rdata_in[7:0];
        table_high_next = prog_rdata_in[15:8];
        state_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (take)
        begin
          case (op_code_in)
            `OP_SBC_ACC, `OP_SUB_ACC, `OP_SUB_IMM,
            `OP_SBC_MEM, `OP_SUB_MEM:
            begin
              // Carry is the not-borrow of the subtractor [RULE_02]
              flags_next = {d_ovf, d_z, d_aux, d_c}; // [RULE_03]
              if ((op_code_in == `OP_SBC_MEM) ||
                  (op_code_in == `OP_SUB_MEM))
              begin
                we_next    = 1'b1; // [RULE_01] [RULE_05]
                wdata_next = diff;
              end
              else
              begin
                acc_next = diff; // [RULE_04] [RULE_06]
              end
            end
            `OP_DEC_SKIP:
            begin
              we_next    = 1'b1;
              wdata_next = dec_val;
              skip_next  = (dec_val == 8'h00); // [RULE_07]
            end
            `OP_DEC_SKIP_A:
            begin
              acc_next  = dec_val;
              skip_next = (dec_val == 8'h00); // [RULE_08]
            end
            `OP_INC_SKIP:
            begin
              we_next    = 1'b1;
              wdata_next = inc_val;
              skip_next  = (inc_val == 8'h00); // [RULE_09]
            end
            `OP_INC_SKIP_A:
            begin
              acc_next  = inc_val;
              skip_next = (inc_val == 8'h00); // [RULE_10]
            end
            `OP_SET_BYTE:
            begin
              we_next    = 1'b1;
              wdata_next = `BYTE_ALL_ONES; // [RULE_12]
            end
            `OP_SET_BIT:
            begin
              we_next    = 1'b1;
              wdata_next = mem_rdata_in | bit_mask; // [RULE_13]
            end
            `OP_BIT_SKIP_NZ:
            begin
              skip_next = sel_bit; // [RULE_14]
            end
            `OP_BIT_SKIP_Z:
            begin
              skip_next = ~sel_bit; // [RULE_15]
            end
            `OP_BYTE_SKIP_Z:
            begin
              skip_next = (mem_rdata_in == 8'h00); // [RULE_16]
            end
            `OP_MOVE_SKIP_Z:
            begin
              acc_next  = mem_rdata_in;
              skip_next = (mem_rdata_in == 8'h00); // [RULE_17]
            end
            `OP_SWAP:
            begin
              we_next    = 1'b1;
              wdata_next = swapped; // [RULE_18]
            end
            `OP_SWAP_A:
            begin
              acc_next = swapped; // [RULE_19]
            end
            `OP_TAB_CUR:
            begin
              pre_next   = 1'b1;
              paddr_next = {pc_in[11:8], table_pointer_in}; // [RULE_20]
              state_next = ST_TABLE;
            end
            `OP_TAB_LAST:
            begin
              pre_next   = 1'b1;
              // Final page of a 4K word store [RULE_21]
              paddr_next = {`PAGE_HI_LAST, table_pointer_in};
              state_next = ST_TABLE;
            end
            default:
            begin
              state_next = ST_RUN;
            end
          endcase
          // A taken skip spends a dummy cycle on the next fetch [RULE_11]
          if (skip_next)
          begin
            state_next = ST_DUMMY;
          end
        end
      end
      default:
      begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg     <= ST_RUN;
      acc_reg       <= `ACC_RESET;
      flags_reg     <= `FLAGS_RESET;
      table_high_reg <= `TABLE_HIGH_RESET;
      mem_we_out    <= 1'b0;
      mem_wdata_out <= 8'h00;
      skip_out      <= 1'b0;
      prog_re_out   <= 1'b0;
      prog_addr_out <= 12'h000;
    end
    else
    begin
      state_reg     <= state_next;
      acc_reg       <= acc_next;
      flags_reg     <= flags_next;
      table_high_reg <= table_high_next;
      mem_we_out    <= we_next;
      mem_wdata_out <= wdata_next;
      skip_out      <= skip_next;
      prog_re_out   <= pre_next;
      prog_addr_out <= paddr_next;
    end
  end
endmodule // subskip_exec
`default_nettype wire

// ===== testbench/core_mem_model.sv
// Data byte and program memory model facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module core_mem_model
(
  // Clock
  input  wire logic        mclk_in,
  // Bench preload of the addressed byte
  input  wire logic        load_in,
  input  wire logic [7:0]  load_data_in,
  // Unit side
  input  wire logic        mem_we_in,
  input  wire logic [7:0]  mem_wdata_in,
  input  wire logic        prog_re_in,
  input  wire logic [11:0] prog_addr_in,
  output var  logic [7:0]  mem_rdata_out,
  output wire logic [15:0] prog_rdata_out
);
  logic        re_d = 1'b0;
  logic [15:0] word;
  // Pattern uses every address bit, so a wrong page reads wrong
  assign word = {~prog_addr_in[7:0], prog_addr_in[11:4]};
  // Outside the read window the word is inverted, never left stale
  assign prog_rdata_out = (prog_re_in || re_d) ? word : ~word;
  always @(posedge mclk_in)
  begin
    re_d <= prog_re_in;
    if (mem_we_in)
      mem_rdata_out <= mem_wdata_in;
    else if (load_in)
      mem_rdata_out <= load_data_in;
  end
endmodule // core_mem_model
`default_nettype wire

// ===== testbench/subskip_checker.sv
// Checker for the subtract, skip and table-read unit
`timescale 1ns/10ps
`default_nettype none
`include "subskip_regs.vh"
module subskip_checker
(
  // Unit inputs
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        op_valid_in,
  input wire logic [4:0]  op_code_in,
  input wire logic [7:0]  imm_in,
  input wire logic [7:0]  mem_rdata_in,
  input wire logic [11:0] pc_in,
  input wire logic [7:0]  table_pointer_in,
  // Unit outputs
  input wire logic        mem_we_out,
  input wire logic [7:0]  mem_wdata_out,
  input wire logic        prog_re_out,
  input wire logic [11:0] prog_addr_out,
  input wire logic        busy_out,
  input wire logic        skip_out,
  input wire logic [7:0]  acc_out,
  input wire logic [3:0]  flags_out,
  input wire logic [7:0]  table_high_byte_out
);
  logic [4:0] op_reg;
  // Opcode taken last edge; refused issues during busy record none
  always @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      op_reg <= `OP_NONE;
    else
      op_reg <= (op_valid_in && !busy_out) ? op_code_in : `OP_NONE;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  dummy_cycle_a: assert property (
    skip_out |-> busy_out ##1 !busy_out)
    else $error("skip without one dummy cycle");
  skip_quiet_a: assert property (
    skip_out |=> !mem_we_out && !skip_out && $stable(acc_out))
    else $error("skipped slot had an effect");
  table_cur_a: assert property (
    op_reg == `OP_TAB_CUR |-> prog_re_out && prog_addr_out ==
    {$past(pc_in[11:8]), $past(table_pointer_in)} ##1 mem_we_out)
    else $error("current page table read wrong");
  table_last_a: assert property (
    op_reg == `OP_TAB_LAST |-> prog_re_out && prog_addr_out ==
    {`PAGE_HI_LAST, $past(table_pointer_in)} ##1 mem_we_out)
    else $error("last page table read wrong");
  table_high_hold_a: assert property (
    !$past(prog_re_out) |-> $stable(table_high_byte_out))
    else $error("table high byte changed outside a read");
  set_byte_a: assert property (
    op_reg == `OP_SET_BYTE |-> mem_we_out && $stable(flags_out)
    && mem_wdata_out == `BYTE_ALL_ONES)
    else $error("set byte wrong");
  swap_a: assert property (
    op_reg == `OP_SWAP |-> mem_we_out && mem_wdata_out ==
    {$past(mem_rdata_in[3:0]), $past(mem_rdata_in[7:4])})
    else $error("nibble swap wrong");
  dec_skip_a: assert property (
    op_reg == `OP_DEC_SKIP |-> mem_wdata_out == $past(mem_rdata_in) - 8'h01
    && skip_out == ($past(mem_rdata_in) == 8'h01))
    else $error("decrement skip wrong");
  sub_imm_a: assert property (
    op_reg == `OP_SUB_IMM |-> acc_out == $past(acc_out) - $past(imm_in)
    && flags_out[`FLAG_C_BIT] == ($past(acc_out) >= $past(imm_in)))
    else $error("subtract immediate wrong");
  skip_c: cover property (skip_out);
  table_c: cover property (prog_re_out);
  sub_c: cover property (op_reg == `OP_SUB_IMM);
endmodule // subskip_checker
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the subtract, skip and table-read unit
`timescale 1ns/10ps
`default_nettype none
`include "subskip_regs.vh"
module testbench;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        op_valid_in = 1'b0;
  logic [4:0]  op_code_in = `OP_NONE;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [7:0]  imm_in = 8'h00;
  logic [11:0] pc_in = 12'h000;
  logic [7:0]  table_pointer_in = 8'h00;
  logic        load = 1'b0;
  logic [7:0]  load_d = 8'h00;
  logic [15:0] prog_rdata_in;
  logic [11:0] prog_addr_out;
  logic [7:0]  mem_rdata_in, mem_wdata_out, acc_out, table_high_byte_out;
  logic        mem_we_out, prog_re_out, busy_out, skip_out;
  logic [3:0]  flags_out, flg_e;
  logic [7:0]  acc_e;
  int          err_total = 0;
  int          check_count = 0;
  always #4 mclk_in = ~mclk_in;
  subskip_exec uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .bit_sel_in(bit_sel_in), .imm_in(imm_in), .mem_rdata_in(mem_rdata_in),
    .pc_in(pc_in), .table_pointer_in(table_pointer_in),
    .prog_rdata_in(prog_rdata_in), .mem_we_out(mem_we_out),
    .mem_wdata_out(mem_wdata_out), .prog_re_out(prog_re_out),
    .prog_addr_out(prog_addr_out), .busy_out(busy_out),
    .skip_out(skip_out), .acc_out(acc_out), .flags_out(flags_out),
    .table_high_byte_out(table_high_byte_out));
  core_mem_model mem_i (.mclk_in(mclk_in), .load_in(load),
    .load_data_in(load_d), .mem_we_in(mem_we_out),
    .mem_wdata_in(mem_wdata_out), .prog_re_in(prog_re_out),
    .prog_addr_in(prog_addr_out), .mem_rdata_out(mem_rdata_in),
    .prog_rdata_out(prog_rdata_in));
  task automatic chk(input string what, input logic [11:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Preload the byte, then issue one operation for a single cycle
  task automatic issue(input logic [4:0] op, input logic [2:0] b,
                       input logic [7:0] m, im);
    @(posedge mclk_in);
    load <= 1'b1;
    load_d <= m;
    @(posedge mclk_in);
    load <= 1'b0;
    op_valid_in <= 1'b1;
    op_code_in <= op;
    bit_sel_in <= b;
    imm_in <= im;
    @(posedge mclk_in);
    op_valid_in <= 1'b0;
    #1;
  endtask
  // Destination d: 0 nothing written, 1 data byte, 2 accumulator
  task automatic do_op(input logic [4:0] op, input logic [2:0] b,
                       input logic [7:0] m, v, input logic s, input int d);
    issue(op, b, m, 8'h00);
    if (d == 2)
      acc_e = v;
    chk("mem_we", 12'(d == 1), mem_we_out);
    if (d == 1)
      chk("wdata", v, mem_wdata_out);
    chk("acc", acc_e, acc_out);
    chk("skip", s, skip_out);
    chk("busy", s, busy_out);
    chk("flags", flg_e, flags_out);
  endtask
  task automatic do_sub(input logic [4:0] op, input logic [7:0] m, im);
    logic [7:0] b, r;
    logic       nc;
    logic       wr;
    b = (op == `OP_SUB_IMM) ? im : m;
    nc = (op == `OP_SBC_MEM || op == `OP_SBC_ACC) & ~flg_e[`FLAG_C_BIT];
    r = acc_e - b - {7'h00, nc};
    wr = (op == `OP_SBC_MEM || op == `OP_SUB_MEM);
    flg_e = {(acc_e[7] != b[7]) && (r[7] != acc_e[7]), r == 8'h00,
             {1'b0, acc_e[3:0]} >= {1'b0, b[3:0]} + {4'h0, nc},
             {1'b0, acc_e} >= {1'b0, b} + {8'h00, nc}};
    issue(op, 3'h0, m, im);
    chk("mem_we", wr, mem_we_out);
    if (wr)
      chk("wdata", r, mem_wdata_out);
    else
      acc_e = r;
    chk("acc", acc_e, acc_out);
    chk("flags", flg_e, flags_out);
  endtask
  task automatic t_sub;
    do_op(`OP_MOVE_SKIP_Z, 3'h0, 8'h50, 8'h50, 1'b0, 2);
    do_sub(`OP_SUB_ACC, 8'h60, 8'h00);
    do_sub(`OP_SBC_MEM, 8'h20, 8'h00);
    do_sub(`OP_SBC_ACC, 8'hF0, 8'h00);
    do_sub(`OP_SUB_IMM, 8'h00, 8'h80);
    do_sub(`OP_SUB_MEM, 8'h7F, 8'h00);
  endtask
  task automatic t_skip;
    do_op(`OP_DEC_SKIP, 3'h0, 8'h01, 8'h00, 1'b1, 1);
    do_op(`OP_DEC_SKIP, 3'h0, 8'h05, 8'h04, 1'b0, 1);
    do_op(`OP_DEC_SKIP_A, 3'h0, 8'h01, 8'h00, 1'b1, 2);
    do_op(`OP_INC_SKIP, 3'h0, 8'hFF, 8'h00, 1'b1, 1);
    do_op(`OP_INC_SKIP_A, 3'h0, 8'h7F, 8'h80, 1'b0, 2);
    do_op(`OP_MOVE_SKIP_Z, 3'h0, 8'h00, 8'h00, 1'b1, 2);
    do_op(`OP_BYTE_SKIP_Z, 3'h0, 8'h00, 8'h00, 1'b1, 0);
    do_op(`OP_BYTE_SKIP_Z, 3'h0, 8'h01, 8'h00, 1'b0, 0);
  endtask
  task automatic t_bits;
    do_op(`OP_SET_BYTE, 3'h0, 8'h12, 8'hFF, 1'b0, 1);
    do_op(`OP_SET_BIT, 3'h5, 8'h01, 8'h21, 1'b0, 1);
    do_op(`OP_SET_BIT, 3'h7, 8'h00, 8'h80, 1'b0, 1);
    do_op(`OP_BIT_SKIP_NZ, 3'h3, 8'h08, 8'h00, 1'b1, 0);
    do_op(`OP_BIT_SKIP_NZ, 3'h3, 8'hF7, 8'h00, 1'b0, 0);
    do_op(`OP_BIT_SKIP_Z, 3'h3, 8'hF7, 8'h00, 1'b1, 0);
    do_op(`OP_BIT_SKIP_Z, 3'h7, 8'h80, 8'h00, 1'b0, 0);
    do_op(`OP_SWAP, 3'h0, 8'h3C, 8'hC3, 1'b0, 1);
    do_op(`OP_SWAP_A, 3'h0, 8'hA5, 8'h5A, 1'b0, 2);
  endtask
  // A set-byte held during the dummy cycle must be dropped
  task automatic t_refuse;
    @(posedge mclk_in);
    load <= 1'b1;
    load_d <= 8'h01;
    @(posedge mclk_in);
    load <= 1'b0;
    op_valid_in <= 1'b1;
    op_code_in <= `OP_DEC_SKIP;
    @(posedge mclk_in);
    op_code_in <= `OP_SET_BYTE;
    #1;
    chk("busy", 1'b1, busy_out);
    @(posedge mclk_in);
    op_valid_in <= 1'b0;
    #1;
    chk("mem_we", 1'b0, mem_we_out);
    chk("busy", 1'b0, busy_out);
  endtask
  task automatic do_tab(input logic [4:0] op, input logic [3:0] pg);
    @(posedge mclk_in);
    pc_in <= 12'h3A5;
    table_pointer_in <= 8'h47;
    issue(op, 3'h0, 8'h00, 8'h00);
    chk("prog_re", 1'b1, prog_re_out);
    chk("prog_addr", {pg, 8'h47}, prog_addr_out);
    @(posedge mclk_in);
    #1;
    chk("mem_we", 1'b1, mem_we_out);
    chk("wdata", {pg, 4'h4}, mem_wdata_out);
    chk("table_high", 8'hB8, table_high_byte_out);
  endtask
  initial
  begin
    repeat (3000) @(posedge mclk_in);
    err_total++;
    $display("ERROR watchdog expired");
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    acc_e = `ACC_RESET;
    flg_e = `FLAGS_RESET;
    #1;
    chk("table_high", `TABLE_HIGH_RESET, table_high_byte_out);
    t_sub();
    $display("t_sub done");
    t_skip();
    $display("t_skip done");
    t_bits();
    $display("t_bits done");
    t_refuse();
    $display("t_refuse done");
    do_tab(`OP_TAB_CUR, 4'h3);
    do_tab(`OP_TAB_LAST, `PAGE_HI_LAST);
    $display("t_table done");
    tally_and_finish();
  end
endmodule // testbench
bind subskip_exec subskip_checker chk_i (.*);
`default_nettype wire
